// ### hw/occ_regs.svh
// Register offsets, field positions and reset values for the compare block
`ifndef OCC_REGS_SVH
`define OCC_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OCC_CTRL_BASE 6'h00
`define OCC_CMPA_BASE 6'h10
`define OCC_CMPB_BASE 6'h20
`define OCC_IRQ_STAT 6'h30
`define OCC_IRQ_EN 6'h34
`define OCC_IRQ_CLR 6'h38
`define OCC_IDLE_REG 6'h3C

// ****************************************************************
// Control fields
// ****************************************************************
`define OCC_IDLE_BIT 13
`define OCC_FLT_BIT 4
`define OCC_TSEL_BIT 3
`define OCC_MODE_LSB 0
`define OCC_CTRL_WMASK 16'h200F
`define OCC_CTRL_RESET 16'h0000

`endif

// ### hw/occ_pkg.sv
// Types shared by the compare block
package occ_pkg;

    typedef enum logic [2:0] {
        OCC_OFF = 3'h0,
        OCC_RISE = 3'h1,
        OCC_FALL = 3'h2,
        OCC_TOGGLE = 3'h3,
        OCC_ONESHOT = 3'h4,
        OCC_PULSES = 3'h5,
        OCC_PWM = 3'h6,
        OCC_PWMF = 3'h7
    } occ_mode_t;

endpackage : occ_pkg

// ### hw/occ_cfg_if.sv
// Per channel settings handed from the register file to a channel
`timescale 1ns/1ps
interface occ_cfg_if;
    logic [2:0] mode;
    logic timeSel;
    logic idleHalt;
    logic [15:0] cmpA;
    logic [15:0] cmpB;
    logic pinOut;
    logic faultSeen;
    logic cmpEvent;
    modport regs (output mode, timeSel, idleHalt, cmpA, cmpB,
        input pinOut, faultSeen, cmpEvent);
    modport chan (input mode, timeSel, idleHalt, cmpA, cmpB,
        output pinOut, faultSeen, cmpEvent);
endinterface : occ_cfg_if

// ### hw/occ_channel.sv
// One output compare channel
`timescale 1ns/1ps
module occ_channel (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Timebases and status
    input wire logic [15:0] timebaseA,
    input wire logic [15:0] timebaseB,
    input wire logic cpuIdle,
    input wire logic faultIn,
    // Settings
    occ_cfg_if.chan cfg
);

    logic [2:0] mode;
    logic [2:0] lastMode;
    logic pin;
    logic fault;
    logic done;
    logic [15:0] count;
    logic run;
    logic modeChange;
    logic hitA;
    logic hitB;
    logic next_pin;

    assign mode = cfg.mode;
    // RQ1 idle halt gate
    assign run = !(cfg.idleHalt && cpuIdle);
    // RQ4 timebase source select
    assign count = cfg.timeSel ? timebaseB : timebaseA;
    // RQ15 compare on equality
    assign hitA = run && (count == cfg.cmpA);
    assign hitB = run && (count == cfg.cmpB);
    assign modeChange = (mode != lastMode);
    assign cfg.cmpEvent = hitA && (mode != 3'h0);
    assign cfg.pinOut = pin;
    // RQ3 flag zero outside mode 111
    assign cfg.faultSeen = fault && (mode == 3'h7);

    always_comb begin
        next_pin = pin;
        case (occ_pkg::occ_mode_t'(mode))
            // RQ12 disabled channel holds low
            occ_pkg::OCC_OFF: next_pin = 1'b0;
            // RQ11 init low, set on compare
            occ_pkg::OCC_RISE: begin
                if (modeChange) next_pin = 1'b0;
                else if (hitA) next_pin = 1'b1;
            end
            // RQ10 init high, clear on compare
            occ_pkg::OCC_FALL: begin
                if (modeChange) next_pin = 1'b1;
                else if (hitA) next_pin = 1'b0;
            end
            // RQ9 toggle on compare
            occ_pkg::OCC_TOGGLE: begin
                if (hitA) next_pin = !pin;
            end
            // RQ8 init low, single pulse
            occ_pkg::OCC_ONESHOT: begin
                if (modeChange) next_pin = 1'b0;
                else if (hitA && !done) next_pin = 1'b1;
                else if (hitB) next_pin = 1'b0;
            end
            // RQ7 init low, repeated pulses
            occ_pkg::OCC_PULSES: begin
                if (modeChange) next_pin = 1'b0;
                else if (hitA) next_pin = 1'b1;
                else if (hitB) next_pin = 1'b0;
            end
            // RQ6 PWM, fault ignored
            occ_pkg::OCC_PWM: begin
                if (run && count == 16'h0000) next_pin = 1'b1;
                if (hitA) next_pin = 1'b0;
            end
            // RQ5 PWM with fault monitoring
            occ_pkg::OCC_PWMF: begin
                if (run && count == 16'h0000) next_pin = 1'b1;
                if (hitA) next_pin = 1'b0;
                // RQ16 fault forces inactive
                if (faultIn || fault) next_pin = 1'b0;
            end
            default: next_pin = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin <= 1'b0;
            lastMode <= 3'h0;
            done <= 1'b0;
        end else begin
            pin <= next_pin;
            lastMode <= mode;
            done <= (mode == 3'h4) && !modeChange && (done || hitA);
        end
    end

    // RQ2 fault flag set, hardware clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fault <= 1'b0;
        end else if (mode == 3'h7 && faultIn) begin
            fault <= 1'b1;
        end else if (mode != 3'h7) begin
            fault <= 1'b0;
        end
    end

endmodule : occ_channel

// ### hw/occ_compare.sv
// Four channel output compare block with Avalon-MM register access
//
// Added by the designer: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`include "occ_regs.svh"

// Notes on behaviour
// RQ1 - Idle halt bit stops channel in idle
// RQ2 - Fault flag read only, hardware cleared
// RQ3 - Fault flag zero outside mode 111
// RQ4 - Timebase select picks B or A
// RQ5 - Mode 111 is PWM with fault
// RQ6 - Mode 110 is PWM without fault
// RQ7 - Mode 101 low then continuous pulses
// RQ8 - Mode 100 low then one pulse
// RQ9 - Mode 011 toggles on compare
// RQ10 - Mode 010 high then low on compare
// RQ11 - Mode 001 low then high on compare
// RQ12 - Mode 000 disables the channel
// RQ13 - Unused control bits read zero
// RQ14 - Four identical independent channels
// RQ15 - Compare event when count equals value
// RQ16 - Fault forces output low, sets flag
module occ_compare #(
    parameter int NUM_CH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Avalon-MM slave
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Timebases and system state
    input wire logic [15:0] timebaseA,
    input wire logic [15:0] timebaseB,
    input wire logic cpuIdle,
    input wire logic [NUM_CH-1:0] faultIn,
    // Pins and interrupt
    output logic [NUM_CH-1:0] comparePin,
    output logic irq
);

    // ****************************************************************
    // Bus handshake
    // ****************************************************************
    logic ack;
    logic [15:0] ctrlReg [NUM_CH];
    logic [15:0] cmpAReg [NUM_CH];
    logic [15:0] cmpBReg [NUM_CH];
    logic [2*NUM_CH-1:0] irqStat;
    logic [2*NUM_CH-1:0] irqEn;
    logic [2*NUM_CH-1:0] events;
    logic [2*NUM_CH-1:0] clrMask;
    logic [NUM_CH-1:0] pins;
    logic [NUM_CH-1:0] flags;
    logic [NUM_CH-1:0] hits;
    logic [NUM_CH-1:0] flagsPrev;
    logic req;
    logic wrAck;
    logic [1:0] chIdx;
    logic [3:0] grp;
    logic [31:0] next_readdata;

    assign req = read || write;
    assign waitrequest = req && !ack;
    assign wrAck = write && !ack;
    assign chIdx = address[3:2];
    assign grp = address[5:4] == 2'h3 ? address[5:2] : {address[5:4], 2'h0};
    assign clrMask = (wrAck && address == `OCC_IRQ_CLR)
        ? writedata[2*NUM_CH-1:0] : '0;
    assign irq = |(irqStat & irqEn);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack <= 1'b0;
        end else begin
            ack <= req && !ack;
        end
    end

    // ****************************************************************
    // Channels
    // ****************************************************************
    // RQ14 four identical channels
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : gCh
            occ_cfg_if cfg ();
            assign cfg.mode = ctrlReg[g][2:0];
            assign cfg.timeSel = ctrlReg[g][`OCC_TSEL_BIT];
            assign cfg.idleHalt = ctrlReg[g][`OCC_IDLE_BIT];
            assign cfg.cmpA = cmpAReg[g];
            assign cfg.cmpB = cmpBReg[g];
            assign pins[g] = cfg.pinOut;
            assign flags[g] = cfg.faultSeen;
            assign hits[g] = cfg.cmpEvent;
            assign events[g] = hits[g];
            assign events[NUM_CH+g] = flags[g] && !flagsPrev[g];

            occ_channel uChan (
                .clk(clk),
                .rstn(rstn),
                .timebaseA(timebaseA),
                .timebaseB(timebaseB),
                .cpuIdle(cpuIdle),
                .faultIn(faultIn[g]),
                .cfg(cfg)
            );

            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    ctrlReg[g] <= `OCC_CTRL_RESET;
                    cmpAReg[g] <= 16'h0000;
                    cmpBReg[g] <= 16'h0000;
                end else if (wrAck && chIdx == 2'(g)) begin
                    if (grp == 4'h0)
                        ctrlReg[g] <= writedata[15:0] & `OCC_CTRL_WMASK;
                    if (grp == 4'h4)
                        cmpAReg[g] <= writedata[15:0];
                    if (grp == 4'h8)
                        cmpBReg[g] <= writedata[15:0];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Interrupt status
    // ****************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irqStat <= '0;
            irqEn <= '0;
            flagsPrev <= '0;
            comparePin <= '0;
        end else begin
            flagsPrev <= flags;
            comparePin <= pins;
            irqStat <= (irqStat & ~clrMask) | events;
            if (wrAck && address == `OCC_IRQ_EN)
                irqEn <= writedata[2*NUM_CH-1:0];
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    always_comb begin
        next_readdata = 32'h0000_0000;
        case (grp)
            // RQ13 unused bits zero
            4'h0: next_readdata = {16'h0000, ctrlReg[chIdx][15:5],
                flags[chIdx], ctrlReg[chIdx][3:0]};
            4'h4: next_readdata = {16'h0000, cmpAReg[chIdx]};
            4'h8: next_readdata = {16'h0000, cmpBReg[chIdx]};
            4'hC: next_readdata = {24'h0, irqStat};
            4'hD: next_readdata = {24'h0, irqEn};
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            readdata <= 32'h0000_0000;
        end else if (read && !ack) begin
            readdata <= next_readdata;
        end
    end

endmodule : occ_compare

// ### verif/occ_timebase_model.sv
// Model of the two timebases that feed the compare block
`timescale 1ns/1ps
module occ_timebase_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Control from the bench
    input wire logic run,
    input wire logic clr,
    // Counts
    output logic [15:0] tbA,
    output logic [15:0] tbB
);
    // B runs a fixed distance ahead of A so the two can be told apart
    assign tbB = tbA + 16'h0100;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tbA <= 16'h0000;
        end else if (clr) begin
            tbA <= 16'h0000;
        end else if (run) begin
            tbA <= (tbA + 16'h0001) & 16'h003F;
        end
    end
endmodule : occ_timebase_model

// ### verif/occ_compare_assertions.sv
// Port checker for the compare block
`timescale 1ns/1ps
module occ_compare_assertions #(
    parameter int NUM_CH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Bus
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Pins
    input wire logic [NUM_CH-1:0] comparePin,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire rdDone = read && !waitrequest;
    wait_first_a: assert property ((read || write) && waitrequest
        |=> !waitrequest) else $error("request not answered");
    wait_rise_a: assert property ($rose(read || write) |-> waitrequest)
        else $error("request answered at once");
    upper_zero_a: assert property (rdDone |-> readdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    unused_bits_a: assert property (
        rdDone && address < 6'h10 |-> readdata[15:14] == 2'h0
        && readdata[12:5] == 8'h00) else $error("unused bits set");
    fault_mode_a: assert property (
        rdDone && address < 6'h10 && readdata[2:0] != 3'h7
        |-> !readdata[4]) else $error("fault flag outside mode");
    unmapped_zero_a: assert property (
        rdDone && address == 6'h3C |-> readdata == 32'h0)
        else $error("unmapped read not zero");
    read_hold_a: assert property (!read |=> $stable(readdata))
        else $error("read data moved");
    reset_quiet_a: assert property ($rose(rstn)
        |-> comparePin == '0 && !irq) else $error("outputs after reset");
endmodule : occ_compare_assertions

bind occ_compare occ_compare_assertions #(.NUM_CH(NUM_CH)) chk_u (
    .clk(clk), .rstn(rstn), .address(address), .read(read),
    .write(write), .readdata(readdata), .waitrequest(waitrequest),
    .comparePin(comparePin), .irq(irq));

// ### verif/occ_compare_tb.sv
// Self-checking bench for the compare block
`timescale 1ns/1ps
module occ_compare_tb;
    logic clk = 1'h0;
    logic rstn = 1'h0;
    logic [5:0] address = 6'h00;
    logic read = 1'h0;
    logic write = 1'h0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic [15:0] tbA;
    logic [15:0] tbB;
    logic cpuIdle = 1'h0;
    logic [3:0] faultIn = 4'h0;
    logic [3:0] comparePin;
    logic irq;
    logic run = 1'h0;
    logic clr = 1'h0;
    logic probe = 1'h0;
    logic [31:0] expQ [$];
    logic [31:0] e;
    logic [31:0] rnd;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;
    int seed = 63958;
    wire [31:0] got = probe ? {27'h0, irq, comparePin} : readdata;
    always #25 clk = ~clk;
    occ_compare dut_u (.clk(clk), .rstn(rstn), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .timebaseA(tbA),
        .timebaseB(tbB), .cpuIdle(cpuIdle), .faultIn(faultIn),
        .comparePin(comparePin), .irq(irq));
    occ_timebase_model tb_u (.clk(clk), .rstn(rstn), .run(run),
        .clr(clr), .tbA(tbA), .tbB(tbB));
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test
    task automatic acc(input logic w, input logic [5:0] a,
        input logic [31:0] d);
        @(posedge clk);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        do begin
            @(posedge clk);
        end while (waitrequest);
        read <= 1'h0;
        write <= 1'h0;
    endtask : acc
    task automatic rd(input logic [5:0] a, input logic [31:0] x);
        expQ.push_back(x);
        acc(1'h0, a, 32'h0);
    endtask : rd
    task automatic pin(input logic [4:0] x);
        expQ.push_back({27'h0, x});
        repeat (4) @(posedge clk);
        probe <= 1'h1;
        @(posedge clk);
        probe <= 1'h0;
    endtask : pin
    task automatic runp(input logic c, input int n);
        @(posedge clk);
        clr <= c;
        @(posedge clk);
        clr <= 1'h0;
        run <= 1'h1;
        repeat (n) @(posedge clk);
        run <= 1'h0;
    endtask : runp
    always @(negedge clk) begin
        if (rstn && ((read && !waitrequest) || probe)) begin
            check_count++;
            e = expQ.pop_front();
            if (got !== e) begin
                errors++;
                $display("wrong value at %0t: got %h expected %h",
                    $time, got, e);
            end
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            finish_test();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'h1;
        for (int i = 0; i < 4; i++) begin
            acc(1'h1, 6'h10 + 6'(i * 4), 32'hA);
            acc(1'h1, 6'h20 + 6'(i * 4), 32'h14);
            rd(6'(i * 4), 32'h0);
        end
        for (int i = 0; i < 4; i++) begin
            rnd = $random(seed);
            acc(1'h1, 6'h0C, rnd);
            rd(6'h0C, rnd & 32'h200F);
            acc(1'h1, 6'h3C, rnd);
            rd(6'h3C, 32'h0);
        end
        acc(1'h1, 6'h0C, 32'h0);
        acc(1'h1, 6'h00, 32'h1);
        acc(1'h1, 6'h04, 32'h2);
        acc(1'h1, 6'h08, 32'h0);
        acc(1'h1, 6'h0C, 32'h3);
        pin(5'h02);
        runp(1'h1, 30);
        pin(5'h09);
        acc(1'h1, 6'h04, 32'h2001);
        acc(1'h1, 6'h18, 32'h105);
        acc(1'h1, 6'h08, 32'hB);
        cpuIdle <= 1'h1;
        runp(1'h1, 30);
        pin(5'h05);
        cpuIdle <= 1'h0;
        runp(1'h1, 30);
        pin(5'h0B);
        acc(1'h1, 6'h18, 32'hA);
        acc(1'h1, 6'h00, 32'h0);
        acc(1'h1, 6'h04, 32'h0);
        acc(1'h1, 6'h08, 32'h4);
        acc(1'h1, 6'h0C, 32'h5);
        pin(5'h00);
        runp(1'h1, 15);
        pin(5'h0C);
        runp(1'h0, 64);
        pin(5'h08);
        acc(1'h1, 6'h08, 32'h0);
        acc(1'h1, 6'h0C, 32'h0);
        acc(1'h1, 6'h00, 32'h7);
        acc(1'h1, 6'h04, 32'h6);
        runp(1'h1, 5);
        acc(1'h1, 6'h38, 32'hFF);
        acc(1'h1, 6'h34, 32'h10);
        rd(6'h30, 32'h0);
        pin(5'h03);
        faultIn <= 4'h1;
        repeat (3) @(posedge clk);
        faultIn <= 4'h0;
        pin(5'h12);
        rd(6'h00, 32'h17);
        acc(1'h1, 6'h30, 32'h0);
        rd(6'h30, 32'h10);
        acc(1'h1, 6'h34, 32'h0);
        pin(5'h02);
        acc(1'h1, 6'h38, 32'h10);
        acc(1'h1, 6'h34, 32'h10);
        rd(6'h30, 32'h0);
        acc(1'h1, 6'h00, 32'h6);
        rd(6'h00, 32'h6);
        finish_test();
    end
endmodule : occ_compare_tb
